/* File: hw/timer_pkg.sv */
package timer_pkg;
    // mode encodings
    localparam logic [1:0] MODE_PRESCALED = 2'h0;
    localparam logic [1:0] MODE_WIDE = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    // field positions in the mode register, per timer nibble
    localparam int MODE_LO_POS = 0;
    localparam int MODE_HI_POS = 1;
    localparam int SRC_SEL_POS = 2;
    localparam int QUALIFY_POS = 3;
    localparam int TIMER_ONE_NIBBLE = 4;
    // timing
    localparam int CLOCKS_PER_CYCLE = 6;
    localparam logic [2:0] CYCLE_LAST = 3'h5;
    localparam logic [2:0] PHASE_RESET = 3'h0;
    // reset values and prescaler maximum
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [4:0] PRESCALE_MAX = 5'h1f;
endpackage

/* File: hw/dual_timer_counter.sv */
`timescale 1ns/10ps
// Operation
// - 16-bit mode: events bump low byte, low overflow bumps high, high overflow sets flag.
// - run enable starts counting from present count contents, nothing cleared.
// - source select: clear counts peripheral cycles, set counts the count pin.
// - clock source increments once per six peripheral clocks.
// - pin source samples once per cycle, counts on high then low sample.
// - falling edge detection spans two cycles; max rate one twelfth of clock.
// - gate clear: run enable alone; gate set: interrupt pin also controls; timer one skips run enable while timer zero is in mode three.
// - rollover from all ones to zeros sets the overflow flag.
// - mode zero: 8-bit high byte after modulo-32 prescaler in low five bits.
// - mode two: low byte counts, reloads from high byte on overflow, sets flag.
// - servicing a timer interrupt clears its overflow flag in hardware.
// - timer zero mode three: low byte uses timer zero controls normally.
// - timer zero mode three: high byte counts cycles using timer one run and flag.
// - timer one modes zero to two as timer zero; mode three halts, holds count.
// - timer zero uses low mode nibble, control bits 4,5; timer one the high nibble and bits 6,7.
// - timer one overflow is offered as the serial baud-rate source.
// - mode codes: 00 prescaled, 01 16-bit, 10 auto-reload, 11 split or halt.
// - gate set: count only while interrupt pin high and run enable set; while timer zero is in mode three, timer one needs only the pin.
module dual_timer_counter #(
    // clocks per peripheral cycle
    parameter int CYCLE_CLOCKS = timer_pkg::CLOCKS_PER_CYCLE
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // mode register write
    input wire logic MODE_WE,
    input wire logic [7:0] MODE_WDATA,
    // control flags: bit4 run zero, bit5 flag zero, bit6 run one, bit7 flag one
    input wire logic CTRL_WE,
    input wire logic [7:0] CTRL_WDATA,
    // count byte writes
    input wire logic LOW_ZERO_WE,
    input wire logic HIGH_ZERO_WE,
    input wire logic LOW_ONE_WE,
    input wire logic HIGH_ONE_WE,
    input wire logic [7:0] COUNT_WDATA,
    // interrupt service acknowledges
    input wire logic SERVICE_ZERO,
    input wire logic SERVICE_ONE,
    // pins
    input wire logic COUNT_PIN_ZERO,
    input wire logic COUNT_PIN_ONE,
    input wire logic EXT_IRQ_PIN_ZERO,
    input wire logic EXT_IRQ_PIN_ONE,
    // state
    output logic [7:0] TIMER_MODE_REGISTER,
    output logic RUN_ENABLE_ZERO,
    output logic RUN_ENABLE_ONE,
    output logic OVERFLOW_FLAG_ZERO,
    output logic OVERFLOW_FLAG_ONE,
    output logic [7:0] COUNT_LOW_ZERO,
    output logic [7:0] COUNT_HIGH_ZERO,
    output logic [7:0] COUNT_LOW_ONE,
    output logic [7:0] COUNT_HIGH_ONE,
    output logic BAUD_TICK
);
    import timer_pkg::*;

    // one timer's increment of its pair; returns {flag, high, low}
    function automatic logic [16:0] step(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
        logic [8:0] lsum;
        logic [8:0] hsum;
        logic [5:0] psum;
        lsum = {1'b0, lo} + 9'h001;
        hsum = {1'b0, hi} + 9'h001;
        psum = {1'b0, lo[4:0]} + 6'h01;
        step = {1'b0, hi, lo};
        unique case (mode)
            MODE_PRESCALED: begin
                // upper three low bits left untouched; their content is meaningless
                if (psum[5]) begin
                    step = {hsum[8], hsum[7:0], lo[7:5], 5'h00};
                end else begin
                    step = {1'b0, hi, lo[7:5], psum[4:0]};
                end
            end
            MODE_WIDE: begin
                if (lsum[8]) begin
                    step = {hsum[8], hsum[7:0], 8'h00};
                end else begin
                    step = {1'b0, hi, lsum[7:0]};
                end
            end
            MODE_RELOAD: begin
                if (lsum[8]) begin
                    step = {1'b1, hi, hi};
                end else begin
                    step = {1'b0, hi, lsum[7:0]};
                end
            end
            MODE_SPLIT: begin
                // 8-bit counter on the low byte only, used by timer zero
                step = {lsum[8], hi, lsum[7:0]};
            end
        endcase
    endfunction

    // count pin edge: high in one sample, low in the next
    function automatic logic pin_fell(input logic earlier, input logic later);
        pin_fell = earlier && !later;
    endfunction

    // gate: run bit alone, or run bit and interrupt pin high when qualified
    function automatic logic gate_open(input logic run, input logic qualify, input logic pin);
        gate_open = run && (!qualify || pin);
    endfunction

    logic [2:0] phase_reg;
    logic cycle_tick;
    logic [1:0] cnt_pin_zero_sync;
    logic [1:0] cnt_pin_one_sync;
    logic [1:0] irq_pin_zero_sync;
    logic [1:0] irq_pin_one_sync;
    logic sample_zero_reg;
    logic sample_one_reg;
    logic prev_zero_reg;
    logic prev_one_reg;
    logic [1:0] mode_zero;
    logic [1:0] mode_one;
    logic gate_ok_zero;
    logic gate_ok_one;
    logic event_zero;
    logic event_one;
    logic split_high_event;
    logic [16:0] next_zero;
    logic [16:0] next_one;
    logic [8:0] split_high_sum;
    logic ovf_zero_set;
    logic ovf_one_set;
    logic timer_one_ovf;
    logic src_event_zero;
    logic src_event_one;
    logic qualify_one_ok;
    localparam logic [2:0] PHASE_LAST = 3'(CYCLE_CLOCKS - 1);

    // phase counter is three bits wide, so only two to eight clocks per cycle fit
    if (CYCLE_CLOCKS < 2 || CYCLE_CLOCKS > 8) begin : g_cycle_check
        $error("clocks per cycle out of range");
    end

    // peripheral cycle divider: six clocks per cycle
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_reg <= PHASE_RESET;
        end else if (CLK_EN) begin
            phase_reg <= (phase_reg == PHASE_LAST) ? PHASE_RESET : phase_reg + 3'h1;
        end
    end
    assign cycle_tick = (phase_reg == PHASE_LAST);

    // count pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_pin_zero_sync <= 2'h0;
            cnt_pin_one_sync <= 2'h0;
        end else if (CLK_EN) begin
            cnt_pin_zero_sync <= {cnt_pin_zero_sync[0], COUNT_PIN_ZERO};
            cnt_pin_one_sync <= {cnt_pin_one_sync[0], COUNT_PIN_ONE};
        end
    end

    // gate pin synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_pin_zero_sync <= 2'h0;
            irq_pin_one_sync <= 2'h0;
        end else if (CLK_EN) begin
            irq_pin_zero_sync <= {irq_pin_zero_sync[0], EXT_IRQ_PIN_ZERO};
            irq_pin_one_sync <= {irq_pin_one_sync[0], EXT_IRQ_PIN_ONE};
        end
    end

    // timer zero pin sampled once per cycle; edge needs two samples, so rate tops out at clk/12
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sample_zero_reg <= 1'b0;
            prev_zero_reg <= 1'b0;
        end else if (CLK_EN && cycle_tick) begin
            sample_zero_reg <= cnt_pin_zero_sync[1];
            prev_zero_reg <= sample_zero_reg;
        end
    end

    // timer one pin sampled the same way
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sample_one_reg <= 1'b0;
            prev_one_reg <= 1'b0;
        end else if (CLK_EN && cycle_tick) begin
            sample_one_reg <= cnt_pin_one_sync[1];
            prev_one_reg <= sample_one_reg;
        end
    end

    assign mode_zero = TIMER_MODE_REGISTER[MODE_HI_POS:MODE_LO_POS];
    assign mode_one = TIMER_MODE_REGISTER[TIMER_ONE_NIBBLE + MODE_HI_POS:TIMER_ONE_NIBBLE + MODE_LO_POS];

    // gate: run alone, or run and interrupt pin high
    assign gate_ok_zero = gate_open(RUN_ENABLE_ZERO, TIMER_MODE_REGISTER[QUALIFY_POS],
        irq_pin_zero_sync[1]);
    assign gate_ok_one = gate_open(RUN_ENABLE_ONE, TIMER_MODE_REGISTER[TIMER_ONE_NIBBLE + QUALIFY_POS],
        irq_pin_one_sync[1]);
    // under timer zero split the run bit belongs to the high byte, so only the pin gates timer one
    assign qualify_one_ok = gate_open(1'b1, TIMER_MODE_REGISTER[TIMER_ONE_NIBBLE + QUALIFY_POS],
        irq_pin_one_sync[1]);

    // source per timer; count pin edge seen at a cycle boundary
    assign src_event_zero = TIMER_MODE_REGISTER[SRC_SEL_POS] ?
        pin_fell(prev_zero_reg, sample_zero_reg) : 1'b1;
    assign src_event_one = TIMER_MODE_REGISTER[TIMER_ONE_NIBBLE + SRC_SEL_POS] ?
        pin_fell(prev_one_reg, sample_one_reg) : 1'b1;

    assign event_zero = cycle_tick && gate_ok_zero && src_event_zero;
    // mode three halts timer one and holds its count
    assign event_one = cycle_tick && (mode_one != MODE_SPLIT) &&
        ((mode_zero == MODE_SPLIT) ? qualify_one_ok : gate_ok_one) && src_event_one;
    assign split_high_event = cycle_tick && (mode_zero == MODE_SPLIT) && RUN_ENABLE_ONE;

    assign next_zero = step(mode_zero, COUNT_LOW_ZERO, COUNT_HIGH_ZERO);
    assign next_one = step(mode_one, COUNT_LOW_ONE, COUNT_HIGH_ONE);
    assign split_high_sum = {1'b0, COUNT_HIGH_ZERO} + 9'h001;

    assign ovf_zero_set = event_zero && next_zero[16];
    assign timer_one_ovf = event_one && next_one[16];
    assign ovf_one_set = (mode_zero == MODE_SPLIT) ? (split_high_event && split_high_sum[8]) : timer_one_ovf;

    // mode register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER_MODE_REGISTER <= MODE_RESET;
        end else if (CLK_EN && MODE_WE) begin
            TIMER_MODE_REGISTER <= MODE_WDATA;
        end
    end

    // timer zero run enable; software owns it
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RUN_ENABLE_ZERO <= 1'b0;
        end else if (CLK_EN && CTRL_WE) begin
            RUN_ENABLE_ZERO <= CTRL_WDATA[4];
        end
    end

    // timer one run enable; also drives the split high byte
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RUN_ENABLE_ONE <= 1'b0;
        end else if (CLK_EN && CTRL_WE) begin
            RUN_ENABLE_ONE <= CTRL_WDATA[6];
        end
    end

    // timer zero flag: hardware set beats service or software clear, so no overflow is lost
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            OVERFLOW_FLAG_ZERO <= 1'b0;
        end else if (CLK_EN) begin
            if (ovf_zero_set) begin
                OVERFLOW_FLAG_ZERO <= 1'b1;
            end else if (SERVICE_ZERO) begin
                OVERFLOW_FLAG_ZERO <= 1'b0;
            end else if (CTRL_WE) begin
                OVERFLOW_FLAG_ZERO <= CTRL_WDATA[5];
            end
        end
    end

    // timer one flag, taken over by the split high byte
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            OVERFLOW_FLAG_ONE <= 1'b0;
        end else if (CLK_EN) begin
            if (ovf_one_set) begin
                OVERFLOW_FLAG_ONE <= 1'b1;
            end else if (SERVICE_ONE) begin
                OVERFLOW_FLAG_ONE <= 1'b0;
            end else if (CTRL_WE) begin
                OVERFLOW_FLAG_ONE <= CTRL_WDATA[7];
            end
        end
    end

    // timer zero low byte; a write wins, software stops the timer first
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            COUNT_LOW_ZERO <= BYTE_RESET;
        end else if (CLK_EN) begin
            if (LOW_ZERO_WE) begin
                COUNT_LOW_ZERO <= COUNT_WDATA;
            end else if (event_zero) begin
                COUNT_LOW_ZERO <= next_zero[7:0];
            end
        end
    end

    // timer zero high byte; reload value may be rewritten at any time
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            COUNT_HIGH_ZERO <= BYTE_RESET;
        end else if (CLK_EN) begin
            if (HIGH_ZERO_WE) begin
                COUNT_HIGH_ZERO <= COUNT_WDATA;
            end else if (mode_zero == MODE_SPLIT) begin
                if (split_high_event) begin
                    COUNT_HIGH_ZERO <= split_high_sum[7:0];
                end
            end else if (event_zero) begin
                COUNT_HIGH_ZERO <= next_zero[15:8];
            end
        end
    end

    // timer one low byte; mode three leaves it frozen
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            COUNT_LOW_ONE <= BYTE_RESET;
        end else if (CLK_EN) begin
            if (LOW_ONE_WE) begin
                COUNT_LOW_ONE <= COUNT_WDATA;
            end else if (event_one) begin
                COUNT_LOW_ONE <= next_one[7:0];
            end
        end
    end

    // timer one high byte
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            COUNT_HIGH_ONE <= BYTE_RESET;
        end else if (CLK_EN) begin
            if (HIGH_ONE_WE) begin
                COUNT_HIGH_ONE <= COUNT_WDATA;
            end else if (event_one) begin
                COUNT_HIGH_ONE <= next_one[15:8];
            end
        end
    end

    // baud source: timer one overflow, registered, valid even while split
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            BAUD_TICK <= 1'b0;
        end else if (CLK_EN) begin
            BAUD_TICK <= timer_one_ovf;
        end
    end
endmodule

/* File: verif/dual_timer_counter_sva.sv */
`timescale 1ns/10ps
module dual_timer_counter_sva (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // writes, service and gate pin
    input wire logic CTRL_WE,
    input wire logic LOW_ZERO_WE,
    input wire logic HIGH_ZERO_WE,
    input wire logic LOW_ONE_WE,
    input wire logic HIGH_ONE_WE,
    input wire logic SERVICE_ZERO,
    input wire logic EXT_IRQ_PIN_ZERO,
    // state
    input wire logic [7:0] TIMER_MODE_REGISTER,
    input wire logic RUN_ENABLE_ZERO,
    input wire logic OVERFLOW_FLAG_ZERO,
    input wire logic [7:0] COUNT_LOW_ZERO,
    input wire logic [7:0] COUNT_HIGH_ZERO,
    input wire logic [7:0] COUNT_LOW_ONE,
    input wire logic [7:0] COUNT_HIGH_ONE
);
    import timer_pkg::*;
    logic [2:0] ph_reg;
    wire [7:0] md = TIMER_MODE_REGISTER;
    // own divider copy, so tick edges are known without peeking inside
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ph_reg <= PHASE_RESET;
        end else if (CLK_EN) begin
            ph_reg <= (ph_reg == CYCLE_LAST) ? PHASE_RESET : ph_reg + 3'h1;
        end
    end
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    property p_tick; $changed(COUNT_LOW_ZERO) && !$past(LOW_ZERO_WE) |-> $past(ph_reg) == CYCLE_LAST; endproperty
    a_tick: assert property (p_tick) else $error("count moved off a tick");
    property p_hold; !RUN_ENABLE_ZERO && !LOW_ZERO_WE |=> $stable(COUNT_LOW_ZERO); endproperty
    a_hold: assert property (p_hold) else $error("stopped timer counted");
    property p_gate; !EXT_IRQ_PIN_ZERO [*4] ##0 (md[3] && !LOW_ZERO_WE) |=> $stable(COUNT_LOW_ZERO); endproperty
    a_gate: assert property (p_gate) else $error("gated timer counted");
    property p_wrap; md[1:0] == MODE_WIDE && COUNT_LOW_ZERO == 8'hff && COUNT_HIGH_ZERO == 8'hff && !LOW_ZERO_WE
        && !HIGH_ZERO_WE ##1 COUNT_LOW_ZERO == 8'h00 |-> COUNT_HIGH_ZERO == 8'h00 && OVERFLOW_FLAG_ZERO; endproperty
    a_wrap: assert property (p_wrap) else $error("wide wrap wrong");
    property p_reload; md[1:0] == MODE_RELOAD && COUNT_LOW_ZERO == 8'hff && !LOW_ZERO_WE ##1 COUNT_LOW_ZERO != 8'hff
        |-> COUNT_LOW_ZERO == $past(COUNT_HIGH_ZERO) && OVERFLOW_FLAG_ZERO; endproperty
    a_reload: assert property (p_reload) else $error("reload wrong");
    property p_pre; md[1:0] == MODE_PRESCALED && !LOW_ZERO_WE |=> COUNT_LOW_ZERO[7:5] == $past(COUNT_LOW_ZERO[7:5]);
    endproperty
    a_pre: assert property (p_pre) else $error("prescaler touched upper bits");
    property p_halt; md[5:4] == MODE_SPLIT && !LOW_ONE_WE && !HIGH_ONE_WE
        |=> $stable(COUNT_LOW_ONE) && $stable(COUNT_HIGH_ONE); endproperty
    a_halt: assert property (p_halt) else $error("halted timer moved");
    property p_svc; SERVICE_ZERO && !CTRL_WE && CLK_EN && ph_reg != CYCLE_LAST |=> !OVERFLOW_FLAG_ZERO; endproperty
    a_svc: assert property (p_svc) else $error("service kept flag");
    c_reload: cover property (md[1:0] == MODE_RELOAD && COUNT_LOW_ZERO == 8'hff ##1 OVERFLOW_FLAG_ZERO);
    c_split: cover property (md[5:4] == MODE_SPLIT && RUN_ENABLE_ZERO);
    c_svc: cover property (SERVICE_ZERO && OVERFLOW_FLAG_ZERO);
endmodule
bind dual_timer_counter dual_timer_counter_sva dual_timer_counter_sva_inst (
    .MCLK(MCLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .CTRL_WE(CTRL_WE), .LOW_ZERO_WE(LOW_ZERO_WE),
    .HIGH_ZERO_WE(HIGH_ZERO_WE), .LOW_ONE_WE(LOW_ONE_WE), .HIGH_ONE_WE(HIGH_ONE_WE), .SERVICE_ZERO(SERVICE_ZERO),
    .EXT_IRQ_PIN_ZERO(EXT_IRQ_PIN_ZERO), .TIMER_MODE_REGISTER(TIMER_MODE_REGISTER), .RUN_ENABLE_ZERO(RUN_ENABLE_ZERO),
    .OVERFLOW_FLAG_ZERO(OVERFLOW_FLAG_ZERO), .COUNT_LOW_ZERO(COUNT_LOW_ZERO), .COUNT_HIGH_ZERO(COUNT_HIGH_ZERO),
    .COUNT_LOW_ONE(COUNT_LOW_ONE), .COUNT_HIGH_ONE(COUNT_HIGH_ONE)
);

/* File: verif/dual_timer_counter_bench.sv */
`timescale 1ns/10ps
module dual_timer_counter_bench;
    import timer_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] we = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [1:0] cpin = 2'b11;
    logic [1:0] irq = 2'b00;
    logic en = 1'b1;
    logic [7:0] tmr, low0, high0, low1, high1;
    logic run0, run1, flag0, flag1, baud;
    logic [31:0] seed = 32'h0000_001c;
    int errors = 0;
    int total_checks = 0;
    int baud_seen = 0;
    always #12.5 mclk = ~mclk;
    // sampled mid-cycle so a one-clock pulse is seen exactly once
    always @(negedge mclk) if (baud === 1'b1) baud_seen++;
    dual_timer_counter dual_timer_counter_inst (
        .MCLK(mclk), .RST_N(rst_n), .CLK_EN(en), .MODE_WE(we[0]), .MODE_WDATA(wd), .CTRL_WE(we[1]),
        .CTRL_WDATA(wd), .LOW_ZERO_WE(we[2]), .HIGH_ZERO_WE(we[3]), .LOW_ONE_WE(we[4]), .HIGH_ONE_WE(we[5]),
        .COUNT_WDATA(wd), .SERVICE_ZERO(we[6]), .SERVICE_ONE(we[7]), .COUNT_PIN_ZERO(cpin[0]),
        .COUNT_PIN_ONE(cpin[1]), .EXT_IRQ_PIN_ZERO(irq[0]), .EXT_IRQ_PIN_ONE(irq[1]), .TIMER_MODE_REGISTER(tmr),
        .RUN_ENABLE_ZERO(run0), .RUN_ENABLE_ONE(run1), .OVERFLOW_FLAG_ZERO(flag0), .OVERFLOW_FLAG_ONE(flag1),
        .COUNT_LOW_ZERO(low0), .COUNT_HIGH_ZERO(high0), .COUNT_LOW_ONE(low1), .COUNT_HIGH_ONE(high1), .BAUD_TICK(baud)
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [23:0] model(input logic [1:0] m, input logic [7:0] hi, input logic [7:0] lo, input int k);
        logic [7:0] ovf;
        logic c;
        ovf = 8'h00;
        for (int i = 0; i < k; i++) begin
            if (m == MODE_RELOAD) begin
                c = (lo == 8'hff);
                lo = c ? hi : lo + 8'h01;
            end else begin
                c = (m == MODE_WIDE) ? (lo == 8'hff) : (lo[4:0] == 5'h1f);
                lo = (m == MODE_WIDE) ? lo + 8'h01 : {lo[7:5], lo[4:0] + 5'h01};
                hi = hi + {7'h00, c};
                c = c && (hi == 8'h00);
            end
            ovf = ovf + {7'h00, c};
        end
        return {ovf, hi, lo};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // we bits: mode, ctrl, low0, high0, low1, high1, service0, service1
    task automatic wr(input int sel, input logic [7:0] d);
        wd = d;
        we = 8'h01 << sel;
        @(negedge mclk);
        we = 8'h00;
        // one quiet cycle, so a following write never reassigns the strobe in the same step
        @(negedge mclk);
    endtask
    // keeps flags as read, so an overflow is not wiped by the stop write
    task automatic stop();
        wr(1, {flag1, 1'b0, flag0, 5'h00});
        idle(3);
    endtask
    task automatic trial(input int t, input logic [1:0] m, input int k);
        logic [31:0] r;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [23:0] e;
        int b;
        r = rnd();
        hi = (m == MODE_RELOAD) ? r[7:0] : 8'hff;
        lo = {4'hf, r[19:16]};
        irq[t] = r[9];
        wr(0, (t == 1) ? {r[8], 1'b0, m, 4'h0} : {4'h0, r[8], 1'b0, m});
        wr(2 + 2 * t, lo);
        wr(3 + 2 * t, hi);
        wr(6 + t, 8'h00);
        chk({7'h00, t ? flag1 : flag0}, 8'h00);
        b = baud_seen;
        wr(1, 8'h10 << (2 * t));
        idle(6 * k - 2);
        stop();
        e = model(m, hi, lo, (r[8] && !r[9]) ? 0 : k);
        chk(t ? low1 : low0, e[7:0]);
        chk(t ? high1 : high0, e[15:8]);
        chk({7'h00, t ? flag1 : flag0}, {7'h00, e[23:16] != 8'h00});
        chk(8'(baud_seen - b), (t == 1) ? e[23:16] : 8'h00);
        $display("trial timer %0d mode %0d done", t, m);
    endtask
    task automatic split(input int k);
        logic [31:0] r;
        logic [7:0] l1;
        logic [7:0] h1;
        r = rnd();
        l1 = low1;
        h1 = high1;
        wr(0, 8'h33);
        wr(2, r[7:0]);
        wr(3, {4'hf, r[11:8]});
        wr(6, 8'h00);
        wr(7, 8'h00);
        wr(1, 8'h50);
        idle(6 * k - 2);
        stop();
        chk(low0, r[7:0] + 8'(k));
        chk({6'h00, flag1, flag0}, {6'h00, {4'hf, r[11:8]} + k > 255, r[7:0] + k > 255});
        chk(high0 ^ low1 ^ high1, ({4'hf, r[11:8]} + 8'(k)) ^ l1 ^ h1);
        $display("split run of %0d ticks done", k);
    endtask
    task automatic pins(input int t, input int n);
        logic [31:0] r;
        int h;
        r = rnd();
        h = 6 + r[9:8];
        wr(0, t ? 8'h50 : 8'h05);
        wr(2 + 2 * t, r[7:0]);
        wr(1, 8'h10 << (2 * t));
        repeat (n) begin
            cpin[t] = 1'b0;
            idle(h);
            cpin[t] = 1'b1;
            idle(h);
        end
        idle(20);
        stop();
        chk(t ? low1 : low0, r[7:0] + 8'(n));
        $display("pin count timer %0d hold %0d done", t, h);
    endtask
    // clock enable low must freeze a running timer
    task automatic freeze(input int k);
        logic [7:0] l0;
        wr(0, 8'h01);
        wr(1, 8'h10);
        idle(6 * k - 2);
        en = 1'b0;
        l0 = low0;
        idle(30);
        chk(low0, l0);
        en = 1'b1;
        stop();
        $display("clock enable freeze done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        idle(8);
        rst_n = 1'b1;
        idle(1);
        chk(tmr | low0 | high0 | low1 | high1, BYTE_RESET);
        chk({3'h0, run0, run1, flag0, flag1, baud}, 8'h00);
        for (int i = 0; i < 24; i++) begin
            trial(i % 2, 2'(i / 2 % 3), (i < 2) ? 1 : 16 + int'(rnd() % 25));
        end
        for (int i = 1; i < 5; i++) begin
            split(i * 9);
            pins(i % 2, i);
        end
        freeze(3);
        end_of_test();
    end
endmodule
